// ---- hdl/temp_loop_pkg.sv ----
package temp_loop_pkg;
  // register word offsets on the plain register port
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_SETPOINT = 8'h01;
  localparam logic [7:0] ADDR_SHIFT    = 8'h02;
  localparam logic [7:0] ADDR_MAN_MV   = 8'h03;
  localparam logic [7:0] ADDR_CYCLE    = 8'h04;
  localparam logic [7:0] ADDR_HB_SET   = 8'h05;
  localparam logic [7:0] ADDR_ALLOC    = 8'h06;
  localparam logic [7:0] ADDR_STATUS   = 8'h07;
  localparam logic [7:0] ADDR_PV       = 8'h08;
  localparam logic [7:0] ADDR_HEATER   = 8'h09;
  localparam logic [7:0] ADDR_PBAND    = 8'h0a;
  localparam logic [7:0] ADDR_ITIME    = 8'h0b;
  localparam logic [7:0] ADDR_DTIME    = 8'h0c;
  localparam logic [7:0] ADDR_RESP     = 8'h0d;

  // control register bit positions
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_MANUAL = 1;
  localparam int CTRL_AT_CMD = 2;

  // answer codes placed in the data word
  localparam logic [15:0] CODE_SENSOR_ERR = 16'he400;
  localparam logic [15:0] CODE_CT_ERR     = 16'he500;
  localparam logic [15:0] CODE_SET_ERR    = 16'hee01;

  // setting ranges, binary two's complement, range units
  localparam logic signed [16:0] LO_PT_C  = 17'sh1f830; // -200.0
  localparam logic signed [16:0] HI_PT_C  = 17'sh01964; //  650.0
  localparam logic signed [16:0] LO_PT_F  = 17'sh1f448; // -300.0
  localparam logic signed [16:0] HI_PT_F  = 17'sh02ee0; // 1200.0
  localparam logic signed [16:0] LO_FINE  = 17'sh1f830; // -20.00
  localparam logic signed [16:0] HI_FINE  = 17'sh061a8; // 250.00
  localparam logic signed [16:0] MARGIN_C = 17'sh000c8; // 20.0 deg
  localparam logic signed [16:0] MARGIN_F = 17'sh007d0; // 20.00 deg
  // bcd indication limits, same raw figures at 0.1 and 0.01
  localparam logic signed [16:0] BCD_LO   = 17'sh1fc19; // -999
  localparam logic signed [16:0] BCD_HI   = 17'sh0270f; // 9999
  localparam logic [3:0]         BCD_NEG  = 4'hf;

  // heater alarm setting and current, 0.1 A units
  localparam logic [9:0]  HB_OFF      = 10'h000;
  localparam logic [9:0]  HB_FORCE_ON = 10'h1f4;  // 50.0 A
  localparam logic [11:0] CT_LIMIT    = 12'h226;  // 55.0 A

  // item codes of the allocation word
  localparam logic [3:0] ITEM_RSVD_A = 4'h9;
  localparam logic [3:0] ITEM_HB     = 4'ha;
  localparam logic [3:0] ITEM_CUR    = 4'hb;
  localparam logic [3:0] ITEM_PV     = 4'h7;

  // manual ratio and timing
  localparam logic [6:0]  MV_FULL      = 7'h64;   // 100 percent
  localparam logic [6:0]  CYCLE_RST    = 7'h14;   // 20 s
  localparam int          CLK_HZ       = 40_000_000;
  localparam int          SLOT_MS      = 10;
  localparam int          SLOT_CYCLES  = CLK_HZ / 1000 * SLOT_MS;
  localparam logic [15:0] SLOTS_PER_TI = 16'h00c8; // 2 s per ti unit
  localparam logic [15:0] SLOTS_PER_TD = 16'h0320; // 8 s per td unit
endpackage : temp_loop_pkg

// ---- hdl/temp_loop_value_and_burnout_alarm.sv ----
`timescale 1ns/10ps
// Operation
// - binary indication out of indication range reports sensor error code.
// - in auto mode a sensor error forces the control output off.
// - bcd at 0.1 degree clamps indication to -99.9 and 999.9.
// - bcd at 0.01 degree clamps indication to -9.99 and 99.99.
// - codes 0 and 1 celsius accept -200.0 to 650.0.
// - codes 0 and 1 fahrenheit accept -300.0 to 1200.0.
// - codes 2 and 3 use 0.01 celsius up to 250.00; host avoids others.
// - indication may exceed setting range by 20 degrees before error.
// - input type change clamps set point into new range.
// - resolution change rescales set point and input shift.
// - manual variable drives time-proportional on/off within control cycle.
// - switching to manual keeps last automatic output level.
// - burnout alarm latches; cleared only by zero setting or power cycle.
// - setting 0.1 to 49.9 is threshold; zero disables, alarm off.
// - setting 50.0 disables detection and forces alarm on.
// - current of 55.0 A or more raises current input error code.
// - indicated value is measured value plus input shift.
// - range check uses the shifted indicated value.
// - parameter writes are refused while autotuning.
// - autotune oscillates on/off, measures period, amplitude, derives pid.
// - start command still present at finish restarts autotuning.
// - power-on state is automatic and stopped until run command.
// - setting item 9 or above 10, or monitor item above 11, gives setting error code; monitor items 4 and 9 read zero.
module temp_loop_value_and_burnout_alarm
  import temp_loop_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_write,
  input  wire logic        i_read,
  output logic      [15:0] o_rdata,
  // switch pins
  input  wire logic [3:0]  i_input_type_switch,
  input  wire logic        i_fahrenheit,
  input  wire logic        i_bcd_mode,
  // measurement from converter logic
  input  wire logic [15:0] i_meas_temp,
  input  wire logic        i_meas_valid,
  input  wire logic [11:0] i_current_sensor_input,
  input  wire logic        i_current_valid,
  // loop outputs
  output logic             o_control_out,
  output logic             o_burnout_alarm_out_one
);

  typedef enum logic [1:0] {
    AT_IDLE = 2'b00,
    AT_WAIT = 2'b01,
    AT_MEAS = 2'b10
  } at_state_e;

  typedef struct packed {
    logic [15:0]        rdata;
    logic [5:0]         sw1, sw2, sw3, sw_cur;
    logic               run, manual, at_cmd;
    logic signed [15:0] setpoint, shift;
    logic [6:0]         mv, cycle;
    logic [9:0]         hb;
    logic [3:0]         set_item, mon_item;
    logic               alloc_err;
    logic signed [15:0] pv;
    logic               sens_err;
    logic [11:0]        current;
    logic               ct_err, alarm, out;
    logic [31:0]        pre;
    logic [13:0]        slot;
    at_state_e          at;
    logic               at_ack, relay;
    logic [15:0]        per;
    logic signed [15:0] amax, amin;
    logic [15:0]        pband, itime, dtime;
  } state_s;

  state_s st_reg, st_next;

  // range lookup: codes 2 and 3 are the fine range, others coarse
  function automatic logic is_fine(input logic [3:0] t);
    return (t == 4'h2) || (t == 4'h3);
  endfunction : is_fine

  function automatic logic signed [16:0] lo_lim(input logic [3:0] t,
                                                input logic f);
    if (is_fine(t)) begin
      return LO_FINE;
    end
    return f ? LO_PT_F : LO_PT_C;
  endfunction : lo_lim

  function automatic logic signed [16:0] hi_lim(input logic [3:0] t,
                                                input logic f);
    if (is_fine(t)) begin
      return HI_FINE;
    end
    return f ? HI_PT_F : HI_PT_C;
  endfunction : hi_lim

  function automatic logic signed [16:0] clamp(input logic signed [16:0] v,
                                               input logic signed [16:0] lo,
                                               input logic signed [16:0] hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction : clamp

  // signed value to four bcd digits, sign as top nibble
  function automatic logic [15:0] to_bcd(input logic signed [16:0] v);
    logic [13:0] a;
    logic [3:0]  d3, d2, d1, d0;
    a  = v[16] ? 14'((-v)) : 14'(v);
    d3 = 4'(a / 14'd1000);
    d2 = 4'((a / 14'd100) % 14'd10);
    d1 = 4'((a / 14'd10) % 14'd10);
    d0 = 4'(a % 14'd10);
    return v[16] ? {BCD_NEG, d2, d1, d0} : {d3, d2, d1, d0};
  endfunction : to_bcd

  // monitored value as it appears in the data word
  function automatic logic [15:0] show(input logic signed [15:0] v,
                                       input logic bcd);
    return bcd ? to_bcd(clamp(17'(v), BCD_LO, BCD_HI)) : v;
  endfunction : show

  logic [3:0]         typ;
  logic               fahr;
  logic               bcd;
  logic signed [16:0] lo, hi, marg, ind, sp_x, sh_x;
  logic               wr_ok, type_chg, slot_tick, mv_on;
  logic [13:0]        slot_end;
  logic [13:0]        mv_slots;
  logic [15:0]        mon_val;

  assign typ  = st_reg.sw_cur[3:0];
  assign fahr = st_reg.sw_cur[4] & ~is_fine(typ);
  assign bcd  = st_reg.sw_cur[5];

  always_comb begin
    st_next = st_reg;
    lo      = lo_lim(typ, fahr);
    hi      = hi_lim(typ, fahr);
    marg    = is_fine(typ) ? MARGIN_F : MARGIN_C;
    ind     = 17'(st_reg.setpoint);
    sp_x    = 17'(st_reg.setpoint);
    sh_x    = 17'(st_reg.shift);

    // pins pass three flops; the first is read only by the second
    st_next.sw1 = {i_bcd_mode, i_fahrenheit, i_input_type_switch};
    st_next.sw2 = st_reg.sw1;
    st_next.sw3 = st_reg.sw2;
    type_chg    = (st_reg.sw2 == st_reg.sw3) &&
                  (st_reg.sw3 != st_reg.sw_cur);
    if (st_reg.sw2 == st_reg.sw3) begin
      st_next.sw_cur = st_reg.sw3;
    end

    // writes other than ctrl are refused while the loop is autotuning
    wr_ok = i_write && (st_reg.at == AT_IDLE);
    if (i_write && i_addr == ADDR_CTRL) begin
      st_next.run    = i_wdata[CTRL_RUN];
      st_next.manual = i_wdata[CTRL_MANUAL];
      st_next.at_cmd = i_wdata[CTRL_AT_CMD];
      // auto to manual keeps the last automatic level
      if (i_wdata[CTRL_MANUAL] && !st_reg.manual) begin
        st_next.mv = st_reg.out ? MV_FULL : 7'h00;
      end
    end
    if (wr_ok) begin
      unique case (i_addr)
        ADDR_SETPOINT: begin
          st_next.setpoint = 16'(clamp(17'(signed'(i_wdata)), lo, hi));
        end
        ADDR_SHIFT: begin
          st_next.shift = 16'(clamp(17'(signed'(i_wdata)), BCD_LO, BCD_HI));
        end
        ADDR_MAN_MV: begin
          st_next.mv = (i_wdata[6:0] > MV_FULL) ? MV_FULL : i_wdata[6:0];
        end
        ADDR_CYCLE: begin
          st_next.cycle = (i_wdata[6:0] == 7'h00) ? 7'h01 : i_wdata[6:0];
        end
        ADDR_HB_SET: begin
          st_next.hb = (i_wdata[9:0] > HB_FORCE_ON) ? HB_FORCE_ON
                                                    : i_wdata[9:0];
        end
        ADDR_ALLOC: begin
          st_next.set_item  = i_wdata[7:4];
          st_next.mon_item  = i_wdata[3:0];
          st_next.alloc_err = (i_wdata[7:4] == ITEM_RSVD_A) ||
                              (i_wdata[7:4] > ITEM_HB) ||
                              (i_wdata[3:0] > ITEM_CUR);
        end
        default: begin
        end
      endcase
    end

    // input type change: rescale on resolution change, then clamp
    if (type_chg) begin
      if (is_fine(st_reg.sw3[3:0]) && !is_fine(typ)) begin
        sp_x = 17'(sp_x * 17'sd10);
        sh_x = 17'(sh_x * 17'sd10);
      end else if (!is_fine(st_reg.sw3[3:0]) && is_fine(typ)) begin
        sp_x = sp_x / 17'sd10;
        sh_x = sh_x / 17'sd10;
      end
      st_next.setpoint = 16'(clamp(sp_x,
                         lo_lim(st_reg.sw3[3:0], st_reg.sw3[4]),
                         hi_lim(st_reg.sw3[3:0], st_reg.sw3[4])));
      st_next.shift    = 16'(clamp(sh_x, BCD_LO, BCD_HI));
    end

    // shifted indication and its range check
    if (i_meas_valid) begin
      ind = 17'(signed'(i_meas_temp)) + 17'(st_reg.shift);
      st_next.pv = 16'(ind);
      st_next.sens_err = (ind < lo - marg) || (ind > hi + marg);
    end

    // heater current and burnout detection
    if (i_current_valid) begin
      st_next.current = i_current_sensor_input;
      st_next.ct_err  = i_current_sensor_input >= CT_LIMIT;
      if (st_reg.out && st_reg.hb != HB_OFF && st_reg.hb < HB_FORCE_ON &&
          i_current_sensor_input < 12'(st_reg.hb)) begin
        st_next.alarm = 1'b1;
      end
    end
    if (st_next.hb == HB_OFF) begin
      st_next.alarm = 1'b0;
    end else if (st_next.hb == HB_FORCE_ON) begin
      st_next.alarm = 1'b1;
    end

    // slot timer for the time-proportional window
    slot_tick = (st_reg.pre == 32'(SLOT_LEN - 1));
    st_next.pre = slot_tick ? 32'h0 : st_reg.pre + 32'h1;
    slot_end  = 14'(st_reg.cycle * MV_FULL);
    mv_slots  = 14'(st_reg.mv * st_reg.cycle);
    if (slot_tick) begin
      st_next.slot = (st_reg.slot >= slot_end - 14'h1) ? 14'h0
                                                     : st_reg.slot + 14'h1;
    end
    mv_on = st_reg.slot < mv_slots;

    // autotuning by relay oscillation around the set point
    st_next.relay = st_reg.pv < st_reg.setpoint;
    if (slot_tick && st_reg.per != 16'hffff) begin
      st_next.per = st_reg.per + 16'h1;
    end
    unique case (st_reg.at)
      AT_IDLE: begin
        st_next.at_ack = st_reg.at_ack & st_reg.at_cmd;
        if (st_reg.at_cmd && st_reg.run && !st_reg.manual) begin
          st_next.at     = AT_WAIT;
          st_next.at_ack = 1'b1;
        end
      end
      AT_WAIT: begin
        // first rising crossing starts the period
        if (st_reg.relay && !st_next.relay) begin
          st_next.at   = AT_MEAS;
          st_next.per  = 16'h0;
          st_next.amax = st_reg.pv;
          st_next.amin = st_reg.pv;
        end
      end
      AT_MEAS: begin
        if (st_reg.pv > st_reg.amax) begin
          st_next.amax = st_reg.pv;
        end
        if (st_reg.pv < st_reg.amin) begin
          st_next.amin = st_reg.pv;
        end
        if (st_reg.relay && !st_next.relay) begin
          st_next.pband = 16'(st_reg.amax - st_reg.amin) << 1;
          st_next.itime = st_reg.per / SLOTS_PER_TI;
          st_next.dtime = st_reg.per / SLOTS_PER_TD;
          // a command left standing runs the tuning again
          st_next.at    = st_reg.at_cmd ? AT_WAIT : AT_IDLE;
        end
      end
      default: begin
        st_next.at = AT_IDLE;
      end
    endcase
    if (!st_reg.run || st_reg.manual) begin
      st_next.at = AT_IDLE;
    end

    // output selection: manual ratio first, then stop or sensor error, then relay on/off
    if (st_reg.manual) begin
      st_next.out = mv_on;
    end else if (!st_reg.run || st_reg.sens_err) begin
      st_next.out = 1'b0;
    end else begin
      st_next.out = st_reg.relay;
    end

    // monitor item for the answer word
    unique case (st_reg.mon_item)
      4'h0:     mon_val = show(st_reg.setpoint, bcd);
      4'h1:     mon_val = st_reg.pband;
      4'h2:     mon_val = st_reg.itime;
      4'h3:     mon_val = st_reg.dtime;
      4'h5:     mon_val = 16'(st_reg.cycle);
      4'h6:     mon_val = show(st_reg.shift, bcd);
      ITEM_PV:  mon_val = st_reg.sens_err ? CODE_SENSOR_ERR
                                          : show(st_reg.pv, bcd);
      4'h8:     mon_val = 16'(st_reg.mv);
      ITEM_HB:  mon_val = 16'(st_reg.hb);
      ITEM_CUR: mon_val = st_reg.ct_err ? CODE_CT_ERR
                                        : 16'(st_reg.current);
      default:  mon_val = 16'h0;
    endcase

    // read data stands one cycle after the strobe
    st_next.rdata = 16'h0;
    if (i_read) begin
      unique case (i_addr)
        ADDR_CTRL:     st_next.rdata = 16'({st_reg.at_cmd, st_reg.manual,
                                            st_reg.run});
        ADDR_SETPOINT: st_next.rdata = st_reg.setpoint;
        ADDR_SHIFT:    st_next.rdata = st_reg.shift;
        ADDR_MAN_MV:   st_next.rdata = 16'(st_reg.mv);
        ADDR_CYCLE:    st_next.rdata = 16'(st_reg.cycle);
        ADDR_HB_SET:   st_next.rdata = 16'(st_reg.hb);
        ADDR_ALLOC:    st_next.rdata = {8'h00, st_reg.set_item,
                                        st_reg.mon_item};
        ADDR_STATUS:   st_next.rdata = 16'({st_reg.alloc_err, st_reg.out,
                                            st_reg.alarm, st_reg.at_ack,
                                            st_reg.at != AT_IDLE,
                                            st_reg.ct_err,
                                            st_reg.sens_err});
        ADDR_PV:       st_next.rdata = st_reg.sens_err ? CODE_SENSOR_ERR
                                       : show(st_reg.pv, bcd);
        ADDR_HEATER:   st_next.rdata = st_reg.ct_err ? CODE_CT_ERR
                                       : 16'(st_reg.current);
        ADDR_PBAND:    st_next.rdata = st_reg.pband;
        ADDR_ITIME:    st_next.rdata = st_reg.itime;
        ADDR_DTIME:    st_next.rdata = st_reg.dtime;
        ADDR_RESP:     st_next.rdata = st_reg.alloc_err ? CODE_SET_ERR
                                       : mon_val;
        default:       st_next.rdata = 16'h0;
      endcase
    end
  end

  // single state register; reset gives auto mode, stopped
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      st_reg        <= '0;
      st_reg.cycle  <= CYCLE_RST;
      st_reg.at     <= AT_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata                 = st_reg.rdata;
  assign o_control_out           = st_reg.out;
  assign o_burnout_alarm_out_one = st_reg.alarm;

endmodule : temp_loop_value_and_burnout_alarm

// ---- tb/temp_loop_checker.sv ----
`timescale 1ns/10ps
module temp_loop_checker
  import temp_loop_pkg::*;
(
  // clock, reset and register port
  input wire logic        i_clock,
  input wire logic        i_reset_n,
  input wire logic [7:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_write,
  input wire logic        i_read,
  input wire logic [15:0] o_rdata,
  // heater current and outputs
  input wire logic [11:0] i_current_sensor_input,
  input wire logic        i_current_valid,
  input wire logic        o_control_out,
  input wire logic        o_burnout_alarm_out_one
);
  logic        run_q;
  logic        man_q;
  logic [11:0] cur_q;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  // mirror of control bits; ctrl is never refused, so this stays exact
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      run_q <= 1'b0;
      man_q <= 1'b0;
      cur_q <= 12'h000;
    end else begin
      if (i_write && i_addr == ADDR_CTRL) begin
        run_q <= i_wdata[CTRL_RUN];
        man_q <= i_wdata[CTRL_MANUAL];
      end
      if (i_current_valid) cur_q <= i_current_sensor_input;
    end
  end

  // multi-step behaviours
  sequence stopped_s;
    !run_q && !man_q;
  endsequence
  sequence bad_alloc_s;
    i_write && i_addr == ADDR_ALLOC && i_wdata[7:4] == ITEM_RSVD_A && !run_q;
  endsequence
  sequence resp_rd_s;
    i_read && i_addr == ADDR_RESP;
  endsequence
  sequence heater_rd_s;
    i_read && i_addr == ADDR_HEATER && !i_current_valid
      && !$past(i_current_valid);
  endsequence

  a_stop_off: assert property (
    stopped_s [*3] |-> !o_control_out) else $error("output on while stopped");
  a_sensor_off: assert property (
    $past(i_read && i_addr == ADDR_STATUS) && o_rdata[0] && !man_q
      |-> ##[0:2] !o_control_out) else $error("output on with sensor error");
  a_alarm_clear: assert property (
    $fell(o_burnout_alarm_out_one) |-> $past(i_write && i_addr == ADDR_HB_SET
      && i_wdata == 16'h0000)) else $error("alarm cleared without zero");
  a_alarm_set: assert property (
    $rose(o_burnout_alarm_out_one) |-> $past(i_current_valid && o_control_out)
      || $past(i_write && i_addr == ADDR_HB_SET && i_wdata >= 16'h01f4))
    else $error("alarm raised without cause");
  a_ct_error: assert property (
    heater_rd_s and (cur_q >= CT_LIMIT) |=> o_rdata == CODE_CT_ERR)
    else $error("current error code missing");
  a_ct_plain: assert property (
    heater_rd_s and (cur_q < CT_LIMIT) |=> o_rdata == {4'h0, cur_q})
    else $error("heater current word wrong");
  a_set_err: assert property (
    bad_alloc_s ##[1:8] resp_rd_s |=> o_rdata == CODE_SET_ERR)
    else $error("setting error code missing");
  a_manual_hold: assert property (
    i_write && i_addr == ADDR_CTRL && i_wdata[CTRL_MANUAL] && !man_q
      && o_control_out |=> o_control_out [*8])
    else $error("manual entry lost output level");
endmodule : temp_loop_checker

bind temp_loop_value_and_burnout_alarm temp_loop_checker u_chk (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
  .i_current_sensor_input(i_current_sensor_input),
  .i_current_valid(i_current_valid), .o_control_out(o_control_out),
  .o_burnout_alarm_out_one(o_burnout_alarm_out_one)
);

// ---- tb/plc_master.sv ----
`timescale 1ns/10ps
module plc_master
  import temp_loop_pkg::*;
(
  // clock and answer
  input  wire logic        i_clock,
  input  wire logic [15:0] i_rdata,
  // request lines
  output logic      [7:0]  o_addr,
  output logic      [15:0] o_wdata,
  output logic             o_write,
  output logic             o_read
);
  // idle bus at time zero
  initial begin
    o_addr  = 8'hff;
    o_wdata = 16'h0000;
    o_write = 1'b0;
    o_read  = 1'b0;
  end

  // one-cycle write; lines then show garbage, not the old word
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clock);
    o_addr  <= a;
    o_wdata <= d;
    o_write <= 1'b1;
    @(posedge i_clock);
    o_write <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask : wr

  // one-cycle read; data stand only in the following cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_read <= 1'b1;
    @(posedge i_clock);
    o_read <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask : rd

  // start autotuning, wait for the ack, then drop the command
  task automatic autotune_start_command(output logic ok);
    logic [15:0] s;
    ok = 1'b0;
    wr(ADDR_CTRL, 16'h0005);
    for (int n = 0; n < 20 && !ok; n++) begin
      rd(ADDR_STATUS, s);
      ok = (s[3] === 1'b1);
    end
    wr(ADDR_CTRL, 16'h0001);
  endtask : autotune_start_command
endmodule : plc_master

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
  import temp_loop_pkg::*;
  typedef struct packed {
    logic [7:0]  wa;
    logic [15:0] wd;
    logic [15:0] mt;
    logic [7:0]  ra;
    logic [15:0] ex;
  } row_s;
  logic        clock   = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        write;
  logic        read;
  logic [15:0] rdata;
  logic [3:0]  tsw     = 4'h0;
  logic        fahr    = 1'b0;
  logic        bcd     = 1'b0;
  logic [15:0] meas    = 16'h0000;
  logic        meas_v  = 1'b0;
  logic [11:0] cur     = 12'h000;
  logic        cur_v   = 1'b0;
  logic        ctl;
  logic        alarm;
  logic        plant   = 1'b0;
  logic        ok;
  logic [7:0]  pc      = 8'h00;
  logic [15:0] d;
  int          n;
  int          err_count = 0;
  int          checked   = 0;
  row_s        rows [13] = '{
    '{ADDR_SETPOINT, 16'h1964, 16'h0000, ADDR_SETPOINT, 16'h1964},
    '{ADDR_SETPOINT, 16'h2000, 16'h0000, ADDR_SETPOINT, 16'h1964},
    '{ADDR_SETPOINT, 16'hf000, 16'h0000, ADDR_SETPOINT, 16'hf830},
    '{ADDR_SHIFT, 16'h0000, 16'h0100, ADDR_PV, 16'h0100},
    '{ADDR_SHIFT, 16'h001e, 16'h0100, ADDR_PV, 16'h011e},
    '{ADDR_SHIFT, 16'h0000, 16'h1a2c, ADDR_PV, 16'h1a2c},
    '{ADDR_SHIFT, 16'h0000, 16'h1a2d, ADDR_PV, 16'he400},
    '{ADDR_SHIFT, 16'h0001, 16'h1a2c, ADDR_PV, 16'he400},
    '{ADDR_SHIFT, 16'h0000, 16'hf768, ADDR_PV, 16'hf768},
    '{ADDR_SHIFT, 16'h0000, 16'hf767, ADDR_PV, 16'he400},
    '{ADDR_ALLOC, 16'h0090, 16'h0000, ADDR_RESP, 16'hee01},
    '{ADDR_ALLOC, 16'h00c0, 16'h0000, ADDR_RESP, 16'hee01},
    '{ADDR_ALLOC, 16'h007b, 16'h0000, ADDR_RESP, 16'h0000}};

  // short slots keep a manual cycle at 400 clocks
  temp_loop_value_and_burnout_alarm #(.SLOT_LEN(4)) u_dut (
    .i_clock(clock), .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata),
    .i_write(write), .i_read(read), .o_rdata(rdata),
    .i_input_type_switch(tsw), .i_fahrenheit(fahr), .i_bcd_mode(bcd),
    .i_meas_temp(meas), .i_meas_valid(meas_v),
    .i_current_sensor_input(cur), .i_current_valid(cur_v),
    .o_control_out(ctl), .o_burnout_alarm_out_one(alarm));
  plc_master u_plc (
    .i_clock(clock), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_write(write), .o_read(read));

  // 40 mhz clock
  initial begin
    forever #12.5 clock = ~clock;
  end

  // crude plant: value creeps toward the relay's side, slow enough
  // that the start handshake finishes before the tune does
  always @(posedge clock) begin
    pc <= pc + 8'h01;
    if (plant) meas_v <= pc[3:0] == 4'h0;
    if (plant && pc[3:0] == 4'h0) meas <= ctl ? meas + 16'h1 : meas - 16'h1;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic bchk(input logic s, input logic e);
    chk({15'h0000, s}, {15'h0000, e});
  endtask : bchk
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    u_plc.rd(a, v);
    chk(v, e);
  endtask : rchk
  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick
  task automatic mpulse(input logic [15:0] t);
    @(posedge clock);
    meas   <= t;
    meas_v <= 1'b1;
    @(posedge clock);
    meas_v <= 1'b0;
    tick(3);
  endtask : mpulse
  task automatic cpulse(input logic [11:0] c);
    @(posedge clock);
    cur   <= c;
    cur_v <= 1'b1;
    @(posedge clock);
    cur_v <= 1'b0;
    tick(3);
  endtask : cpulse
  // pins are synchronised, so give them time to settle
  task automatic pins(input logic [3:0] t, input logic f, input logic b);
    @(posedge clock);
    tsw  <= t;
    fahr <= f;
    bcd  <= b;
    tick(10);
  endtask : pins
  task automatic wait_ctl(input logic v);
    for (int k = 0; k < 2000 && ctl !== v; k++) @(posedge clock);
    if (ctl !== v) begin
      $display("CHECK FAILED %0t output wait", $time);
      err_count++;
      report_and_stop();
    end
  endtask : wait_ctl

  // watchdog
  initial begin
    #2_000_000;
    err_count++;
    report_and_stop();
  end

  initial begin
    tick(6);
    reset_n <= 1'b1;
    tick(2);
    bchk(ctl, 1'b0);
    rchk(ADDR_CTRL, 16'h0000);
    foreach (rows[i]) begin
      u_plc.wr(rows[i].wa, rows[i].wd);
      mpulse(rows[i].mt);
      rchk(rows[i].ra, rows[i].ex);
    end
    pins(4'h0, 1'b1, 1'b0);
    u_plc.wr(ADDR_SETPOINT, 16'h3000);
    rchk(ADDR_SETPOINT, 16'h2ee0);
    u_plc.wr(ADDR_SETPOINT, 16'hf000);
    rchk(ADDR_SETPOINT, 16'hf448);
    u_plc.wr(ADDR_SETPOINT, 16'h2000);
    pins(4'h0, 1'b0, 1'b0);
    rchk(ADDR_SETPOINT, 16'h1964);
    u_plc.wr(ADDR_SHIFT, 16'h001e);
    pins(4'h2, 1'b0, 1'b0);
    rchk(ADDR_SETPOINT, 16'h61a8);
    rchk(ADDR_SHIFT, 16'h012c);
    u_plc.wr(ADDR_SHIFT, 16'h0000);
    pins(4'h2, 1'b0, 1'b1);
    mpulse(16'h2710);
    rchk(ADDR_PV, 16'h9999);
    mpulse(16'hfa24);
    rchk(ADDR_PV, 16'hf999);
    pins(4'h0, 1'b0, 1'b1);
    mpulse(16'hfa24);
    rchk(ADDR_PV, 16'hf999);
    pins(4'h0, 1'b1, 1'b1);
    mpulse(16'h2af8);
    rchk(ADDR_PV, 16'h9999);
    pins(4'h0, 1'b0, 1'b0);
    u_plc.wr(ADDR_HB_SET, 16'h01f4);
    tick(2);
    bchk(alarm, 1'b1);
    u_plc.wr(ADDR_HB_SET, 16'h0000);
    tick(2);
    bchk(alarm, 1'b0);
    u_plc.wr(ADDR_HB_SET, 16'h0064);
    u_plc.wr(ADDR_SETPOINT, 16'h03e8);
    mpulse(16'h0000);
    u_plc.wr(ADDR_CTRL, 16'h0001);
    wait_ctl(1'b1);
    cpulse(12'h0c8);
    bchk(alarm, 1'b0);
    cpulse(12'h032);
    bchk(alarm, 1'b1);
    cpulse(12'h0c8);
    bchk(alarm, 1'b1);
    cpulse(12'h226);
    rchk(ADDR_HEATER, 16'he500);
    cpulse(12'h225);
    rchk(ADDR_HEATER, 16'h0225);
    u_plc.wr(ADDR_HB_SET, 16'h0000);
    tick(2);
    bchk(alarm, 1'b0);
    mpulse(16'h1b00);
    u_plc.rd(ADDR_STATUS, d);
    bchk(d[0], 1'b1);
    bchk(ctl, 1'b0);
    mpulse(16'h0000);
    wait_ctl(1'b1);
    u_plc.wr(ADDR_CTRL, 16'h0003);
    tick(40);
    bchk(ctl, 1'b1);
    u_plc.wr(ADDR_CYCLE, 16'h0001);
    u_plc.wr(ADDR_MAN_MV, 16'h0032);
    tick(8);
    n = 0;
    repeat (400) begin
      @(negedge clock);
      n += int'(ctl);
    end
    chk(n[15:0], 16'd200);
    u_plc.wr(ADDR_MAN_MV, 16'h0000);
    tick(5);
    bchk(ctl, 1'b0);
    u_plc.wr(ADDR_CTRL, 16'h0000);
    u_plc.wr(ADDR_SETPOINT, 16'h0100);
    mpulse(16'h00f0);
    plant <= 1'b1;
    u_plc.autotune_start_command(ok);
    bchk(ok, 1'b1);
    u_plc.rd(ADDR_STATUS, d);
    bchk(d[2], 1'b1);
    u_plc.wr(ADDR_SETPOINT, 16'h0200);
    rchk(ADDR_SETPOINT, 16'h0100);
    d = 16'h0004;
    for (int k = 0; k < 400 && d[2] !== 1'b0; k++) u_plc.rd(ADDR_STATUS, d);
    bchk(d[2], 1'b0);
    u_plc.rd(ADDR_PBAND, d);
    bchk(d == 16'h0000, 1'b0);
    plant <= 1'b0;
    report_and_stop();
  end
endmodule : tb
